// ==== src/bus_control_pkg.sv ====
package bus_control_pkg;

    // Register map, byte addresses as printed.
    localparam logic [31:0] BUS_CONTROL_ADDR       = 32'h5000_1300;
    localparam logic [31:0] STD_HIGH_COUNT_ADDR    = 32'h5000_1314;
    localparam logic [31:0] STD_LOW_COUNT_ADDR     = 32'h5000_1318;
    localparam logic [31:0] FAST_HIGH_COUNT_ADDR   = 32'h5000_131C;
    localparam logic [31:0] FAST_LOW_COUNT_ADDR    = 32'h5000_1320;

    // Field positions of the control register.
    localparam int INITIATOR_EN_BIT    = 0;
    localparam int SPEED_LSB           = 1;
    localparam int SPEED_MSB           = 2;
    localparam int TARGET_WIDE_BIT     = 3;
    localparam int INITIATOR_WIDE_BIT  = 4;
    localparam int RESTART_EN_BIT      = 5;
    localparam int TARGET_DISABLE_BIT  = 6;
    localparam int CONTROL_USED_BITS   = 7;

    // Values after reset.
    localparam logic [15:0] BUS_CONTROL_RESET = 16'h007D;
    localparam logic [15:0] STD_HIGH_RESET    = 16'h0048;
    localparam logic [15:0] STD_LOW_RESET     = 16'h004F;
    localparam logic [15:0] FAST_HIGH_RESET   = 16'h0008;
    localparam logic [15:0] FAST_LOW_RESET    = 16'h0017;

    // Speed field encodings.
    localparam logic [1:0] SPEED_STANDARD = 2'h1;
    localparam logic [1:0] SPEED_FAST     = 2'h2;

endpackage

// ==== src/bus_control.sv ====
// Function
// - Bit 6 set disables target role, resets one.
// - Bit 5 permits repeated starts, resets one.
// - Bit 4 picks initiator 10-bit addressing.
// - Bit 3 picks target 10-bit addressing.
// - Bits 2:1 select standard or fast speed.
// - Speed picks standard or fast clock counts.
// - Bit 0 enables initiator role, resets one.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module bus_control #(
    parameter int ADDR_W = 32
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_write,
    input  wire logic              i_read,
    output logic      [15:0]       o_rdata,
    output logic                   o_initiator_enable,
    output logic                   o_target_enable,
    output logic                   o_restart_enable,
    output logic                   o_initiator_wide_addressing,
    output logic                   o_target_wide_addressing,
    output logic                   o_fast_mode,
    output logic      [15:0]       o_clock_high_count,
    output logic      [15:0]       o_clock_low_count
);

    // The decode compares whole 32-bit bus addresses, so no other width can be served.
    if (ADDR_W != 32) begin : g_addr_check
        $error("bus_control needs a 32-bit address");
    end

    typedef struct packed {
        logic [15:0] control;
        logic [15:0] standard_clock_high_count;
        logic [15:0] standard_clock_low_count;
        logic [15:0] fast_clock_high_count;
        logic [15:0] fast_clock_low_count;
        logic [15:0] rdata;
        logic [15:0] high_count;
        logic [15:0] low_count;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic   fast_sel;

    // Only the value 2 picks the fast counts; any other code keeps the safer standard rate.
    assign fast_sel = (state_reg.control[bus_control_pkg::SPEED_MSB:bus_control_pkg::SPEED_LSB]
                       == bus_control_pkg::SPEED_FAST);

    // Register writes, read data and the count selection, all computed from current state.
    always_comb begin
        state_next = state_reg;
        if (i_write) begin
            unique case (i_addr)
                bus_control_pkg::BUS_CONTROL_ADDR: begin
                    // Upper bits are masked so they stay zero.
                    state_next.control = i_wdata & 16'h007F;
                end
                bus_control_pkg::STD_HIGH_COUNT_ADDR: begin
                    state_next.standard_clock_high_count = i_wdata;
                end
                bus_control_pkg::STD_LOW_COUNT_ADDR: begin
                    state_next.standard_clock_low_count = i_wdata;
                end
                bus_control_pkg::FAST_HIGH_COUNT_ADDR: begin
                    state_next.fast_clock_high_count = i_wdata;
                end
                bus_control_pkg::FAST_LOW_COUNT_ADDR: begin
                    state_next.fast_clock_low_count = i_wdata;
                end
                default: begin
                    state_next.control = state_reg.control;
                end
            endcase
        end
        // Unmapped reads, and cycles without a read, return zero.
        state_next.rdata = 16'h0000;
        if (i_read) begin
            unique case (i_addr)
                bus_control_pkg::BUS_CONTROL_ADDR: begin
                    state_next.rdata = state_reg.control;
                end
                bus_control_pkg::STD_HIGH_COUNT_ADDR: begin
                    state_next.rdata = state_reg.standard_clock_high_count;
                end
                bus_control_pkg::STD_LOW_COUNT_ADDR: begin
                    state_next.rdata = state_reg.standard_clock_low_count;
                end
                bus_control_pkg::FAST_HIGH_COUNT_ADDR: begin
                    state_next.rdata = state_reg.fast_clock_high_count;
                end
                bus_control_pkg::FAST_LOW_COUNT_ADDR: begin
                    state_next.rdata = state_reg.fast_clock_low_count;
                end
                default: begin
                    state_next.rdata = 16'h0000;
                end
            endcase
        end
        // Counts are registered so the timer sees glitch-free values.
        state_next.high_count = fast_sel ? state_reg.fast_clock_high_count
                                         : state_reg.standard_clock_high_count;
        state_next.low_count  = fast_sel ? state_reg.fast_clock_low_count
                                         : state_reg.standard_clock_low_count;
    end

    // State register with synchronous reset.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg.control                   <= bus_control_pkg::BUS_CONTROL_RESET;
            state_reg.standard_clock_high_count <= bus_control_pkg::STD_HIGH_RESET;
            state_reg.standard_clock_low_count  <= bus_control_pkg::STD_LOW_RESET;
            state_reg.fast_clock_high_count     <= bus_control_pkg::FAST_HIGH_RESET;
            state_reg.fast_clock_low_count      <= bus_control_pkg::FAST_LOW_RESET;
            state_reg.rdata                     <= 16'h0000;
            state_reg.high_count                <= bus_control_pkg::FAST_HIGH_RESET;
            state_reg.low_count                 <= bus_control_pkg::FAST_LOW_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Role and format outputs straight from the control flops.
    // Both roles can be enabled together if software misbehaves; the hardware does not arbitrate.
    assign o_initiator_enable          = state_reg.control[bus_control_pkg::INITIATOR_EN_BIT];
    assign o_target_enable             = ~state_reg.control[bus_control_pkg::TARGET_DISABLE_BIT];
    assign o_restart_enable            = state_reg.control[bus_control_pkg::RESTART_EN_BIT];
    assign o_initiator_wide_addressing = state_reg.control[bus_control_pkg::INITIATOR_WIDE_BIT];
    assign o_target_wide_addressing    = state_reg.control[bus_control_pkg::TARGET_WIDE_BIT];
    assign o_fast_mode                 = fast_sel;
    assign o_clock_high_count          = state_reg.high_count;
    assign o_clock_low_count           = state_reg.low_count;
    assign o_rdata                     = state_reg.rdata;

    // Upper control bits never become set.
    upper_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_reg.control[15:7] == 9'h000) else $error("upper control bits set");

    // Leaving reset shows the reset control value and the fast high count that it selects.
    reset_value_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        $fell(i_reset) |-> (state_reg.control == bus_control_pkg::BUS_CONTROL_RESET
                            && o_clock_high_count == bus_control_pkg::FAST_HIGH_RESET))
        else $error("reset values wrong");

    // A write to control shows on the target enable one cycle later.
    target_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_target_enable == !$past(i_wdata[6]))) else $error("target enable wrong");

    // Restart permission follows bit 5.
    restart_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_restart_enable == $past(i_wdata[5]))) else $error("restart enable wrong");

    // Initiator address width follows bit 4.
    init_wide_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_initiator_wide_addressing == $past(i_wdata[4]))) else $error("init width wrong");

    // Target address width follows bit 3.
    target_wide_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_target_wide_addressing == $past(i_wdata[3]))) else $error("target width wrong");

    // Fast mode exactly when the speed field holds two.
    speed_field_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_fast_mode == ($past(i_wdata[2:1]) == 2'h2))) else $error("speed decode wrong");

    // Control changes only on its own write, so traffic to the counts leaves the roles alone.
    control_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !(i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> $stable(state_reg.control))
        else $error("control changed without write");

    // The selected high count matches the speed one cycle later when unchanged.
    count_select_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (!i_write && $stable(fast_sel)) |=> (o_clock_high_count ==
         ($past(fast_sel) ? state_reg.fast_clock_high_count
                          : state_reg.standard_clock_high_count)))
        else $error("count select wrong");

    // The low count follows the same selection as the high count.
    low_select_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (!i_write && $stable(fast_sel)) |=> (o_clock_low_count ==
         ($past(fast_sel) ? state_reg.fast_clock_low_count
                          : state_reg.standard_clock_low_count)))
        else $error("low count select wrong");

    // Each count write lands whole, all 16 bits, one cycle later, so software can trim freely.
    std_high_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::STD_HIGH_COUNT_ADDR)
        |=> (state_reg.standard_clock_high_count == $past(i_wdata)))
        else $error("standard high count write lost");

    std_low_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::STD_LOW_COUNT_ADDR)
        |=> (state_reg.standard_clock_low_count == $past(i_wdata)))
        else $error("standard low count write lost");

    fast_high_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::FAST_HIGH_COUNT_ADDR)
        |=> (state_reg.fast_clock_high_count == $past(i_wdata)))
        else $error("fast high count write lost");

    fast_low_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::FAST_LOW_COUNT_ADDR)
        |=> (state_reg.fast_clock_low_count == $past(i_wdata)))
        else $error("fast low count write lost");

    // Initiator enable follows bit 0.
    init_enable_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_write && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_initiator_enable == $past(i_wdata[0]))) else $error("initiator enable wrong");

    // Reading control returns it with zero upper bits.
    control_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_read && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_rdata[15:7] == 9'h000)) else $error("control read upper bits");

    // A control read hands back the seven used bits exactly as they stood.
    control_value_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_read && i_addr == bus_control_pkg::BUS_CONTROL_ADDR)
        |=> (o_rdata == {9'h000, $past(state_reg.control[6:0])}))
        else $error("control read value wrong");

endmodule
`default_nettype wire

// ==== verif/bus_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Software side of the register port; one access at a time, no gap-free tricks needed.
module bus_master_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_rdata,
    output logic      [31:0] o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_write,
    output logic             o_read
);
    // Idle lines start at zero; after each access the address flips, and after a write the data too, so stale values never look valid.
    initial begin
        o_addr = 32'h0;
        o_wdata = 16'h0;
        o_write = 1'b0;
        o_read = 1'b0;
    end
    task automatic put(input logic [31:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wdata <= d;
        o_write <= 1'b1;
        @(posedge i_clk_sys);
        o_write <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1;
    endtask
    // Read data is taken in the one cycle after the strobe, once it has settled.
    task automatic get(input logic [31:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_read <= 1'b1;
        @(posedge i_clk_sys);
        o_read <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_bus_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_bus_control;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    wire  [31:0] addr;
    wire  [15:0] wdata, rdata, hi_cnt, lo_cnt;
    wire         write, read, ie, te, re, iw, tw, fm;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [15:0] rd, d, ctl;
    logic [15:0] cnt [4];
    int          j;
    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;
    bus_master_model bus_u (.i_clk_sys(clk_sys), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_write(write), .o_read(read));
    bus_control dut_u (.i_clk_sys(clk_sys), .i_reset(reset), .i_addr(addr), .i_wdata(wdata),
        .i_write(write), .i_read(read), .o_rdata(rdata), .o_initiator_enable(ie),
        .o_target_enable(te), .o_restart_enable(re), .o_initiator_wide_addressing(iw),
        .o_target_wide_addressing(tw), .o_fast_mode(fm), .o_clock_high_count(hi_cnt),
        .o_clock_low_count(lo_cnt));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Software never leaves both roles on, so initiator on forces target off.
    function automatic logic [15:0] legal(input logic [15:0] v);
        legal = v;
        if (v[0]) legal[6] = 1'b1;
    endfunction
    // Compares every decoded output and the selected counts against control value c.
    task automatic outs(input logic [15:0] c);
        check("initiator", {15'h0, ie}, {15'h0, c[0]});
        check("target", {15'h0, te}, {15'h0, ~c[6]});
        check("restart", {15'h0, re}, {15'h0, c[5]});
        check("init wide", {15'h0, iw}, {15'h0, c[4]});
        check("targ wide", {15'h0, tw}, {15'h0, c[3]});
        check("fast", {15'h0, fm}, {15'h0, c[2:1] == 2'h2});
        check("high count", hi_cnt, (c[2:1] == 2'h2) ? cnt[2] : cnt[0]);
        check("low count", lo_cnt, (c[2:1] == 2'h2) ? cnt[3] : cnt[1]);
    endtask
    // Main sequence: reset values, every speed code, random traffic, unmapped access.
    initial begin
        void'($urandom(32'h8aee));
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        cnt = '{16'h0048, 16'h004F, 16'h0008, 16'h0017};
        ctl = 16'h007D;
        bus_u.get(bus_control_pkg::BUS_CONTROL_ADDR, rd);
        check("reset control", rd, ctl);
        outs(ctl);
        // Read data stand for one cycle only and then fall back to zero.
        @(posedge clk_sys);
        #1;
        check("read idle", rdata, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            j = $urandom % 4;
            cnt[j] = 16'($urandom);
            bus_u.put(bus_control_pkg::STD_HIGH_COUNT_ADDR + 32'(4 * j), cnt[j]);
            d = 16'($urandom);
            if (i < 4) d[2:1] = i[1:0];
            d = legal(d);
            bus_u.put(bus_control_pkg::BUS_CONTROL_ADDR, d);
            ctl = d & 16'h007F;
            bus_u.get(bus_control_pkg::BUS_CONTROL_ADDR, rd);
            check("control", rd, ctl);
            outs(ctl);
        end
        // A second reset in mid-run must restore every register, counts included.
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        cnt = '{16'h0048, 16'h004F, 16'h0008, 16'h0017};
        ctl = 16'h007D;
        bus_u.get(bus_control_pkg::BUS_CONTROL_ADDR, rd);
        check("reset again", rd, ctl);
        outs(ctl);
        bus_u.put(bus_control_pkg::BUS_CONTROL_ADDR + 32'h8, 16'hFFFF);
        bus_u.get(bus_control_pkg::BUS_CONTROL_ADDR + 32'h8, rd);
        check("unmapped", rd, 16'h0000);
        bus_u.get(bus_control_pkg::BUS_CONTROL_ADDR, rd);
        check("control kept", rd, ctl);
        tally_and_finish;
    end
    // The whole sequence needs well under 1000 cycles; this limit only catches a hang.
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
